// file: verilog/parity_status_pkg.sv
// Constants for the first-level memory parity error status block.
package parity_status_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] STATUS_OFS = 4'h0;
   localparam logic [3:0] EVENT_OFS = 4'h4;
   localparam logic [3:0] MASK_OFS = 4'h8;

   // ----------------------------------------------------------------
   // Status register bit positions
   // ----------------------------------------------------------------
   localparam int CORE_FETCH_ERR = 31;
   localparam int CORE_FETCH_IRQ_FLAG = 30;
   localparam int CORE_DATA_ERR = 29;
   localparam int CORE_DATA_IRQ_FLAG = 28;
   localparam int SYS_XFER_ERR = 27;
   localparam int SYS_XFER_IRQ_FLAG = 26;
   localparam int PROGMEM_FETCH_ERR = 7;
   localparam int ADDR_GEN_ONE_ERR = 6;
   localparam int ADDR_GEN_TWO_ERR = 5;
   localparam int SLAVE_PORT_TWO_ERR = 4;
   localparam int SLAVE_PORT_ONE_ERR = 3;
   localparam int ICACHE_ERR = 2;
   localparam int DATA_CACHE_ERR = 1;
   localparam int PROG_CACHE_ERR = 0;

   // Implemented bits; 25 down to 8 always read zero
   localparam logic [31:0] STATUS_IMPL_MASK = 32'hFC0000FF;
   // Interrupt flag bits, which may still set while the error is locked
   localparam logic [31:0] STATUS_IRQ_MASK = 32'h54000000;
   localparam logic [31:0] STATUS_RESET = 32'h00000000;

   // ----------------------------------------------------------------
   // Event and mask register layout
   // ----------------------------------------------------------------
   localparam int EVT_FETCH = 0;
   localparam int EVT_DATA = 1;
   localparam int EVT_SYS = 2;
   localparam int EVT_W = 3;
   localparam logic [2:0] EVT_RESET = 3'h0;
   localparam logic [2:0] MASK_RESET = 3'h0;
endpackage : parity_status_pkg

// file: verilog/l1_parity_error_status.sv
// Parity error status collector with Avalon-MM register slave.
//
// Function
// R1 - Capture parity errors of all memory read types
// R2 - Recorded error stays locked until fully cleared
// R3 - Writing zero to status clears all bits
// R4 - Handler software writes zero to stop repeats
// R5 - Same-cycle data-memory and program-memory: keep data-memory
// R6 - Same-cycle slave ports: keep first slave port
// R7 - Bits 31/30: instruction read error, interrupt
// R8 - Bits 29/28: core data read error, interrupt
// R9 - Bits 27/26: system transfer error, interrupt
// R10 - Interrupt flag sets only when latched by core
// R11 - Bit 7: program memory fetch error
// R12 - Bits 6/5: address generator one, two errors
// R13 - Bits 4/3: slave port two, one errors
// R14 - Bit 2: instruction cache read error
// R15 - Bits 1/0: data cache, program cache errors
// R16 - Summary and detail set together; 25:8 zero
// R17 - Core reset clears every status bit
`timescale 1ns/1ps
module l1_parity_error_status (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Parity checker error strobes, one cycle each
   input wire logic progmem_fetch_err,
   input wire logic addr_gen_one_err,
   input wire logic addr_gen_two_err,
   input wire logic slave_port_one_err,
   input wire logic slave_port_two_err,
   input wire logic icache_err,
   input wire logic data_cache_err,
   input wire logic prog_cache_err,
   // Interrupt latch: parity interrupt latched for each category
   input wire logic fetch_irq_latched,
   input wire logic data_irq_latched,
   input wire logic sys_irq_latched,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Interrupt request to the core interrupt latch
   output logic parity_interrupt
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [31:0] status_q;
   logic [31:0] status_d;
   logic [31:0] detect;
   logic [2:0] evt_q;
   logic [2:0] evt_d;
   logic [2:0] mask_q;
   logic [2:0] cat_err;
   logic [31:0] wmask;
   logic [31:0] rd_mux;
   logic wait_q;
   logic [31:0] rdata_q;
   logic irq_q;
   logic acc;
   logic wr_status;
   logic wr_event;
   logic wr_mask;
   logic clear_zero;
   logic capture;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // A request is accepted in the cycle waitrequest is low
   assign acc = (read || write) && !wait_q;
   assign wr_status = acc && write && address == parity_status_pkg::STATUS_OFS;
   assign wr_event = acc && write && address == parity_status_pkg::EVENT_OFS;
   assign wr_mask = acc && write && address == parity_status_pkg::MASK_OFS;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{byteenable[i]}};
      end
   end

   // Only a word whose enabled lanes are all zero counts as a clear
   assign clear_zero = wr_status && ((writedata & wmask) == 32'h00000000);

   // ----------------------------------------------------------------
   // Error detection with priorities
   // ----------------------------------------------------------------
   always_comb begin
      detect = 32'h00000000;
      detect[parity_status_pkg::PROGMEM_FETCH_ERR] = progmem_fetch_err; // R11
      detect[parity_status_pkg::ICACHE_ERR] = icache_err; // R14
      detect[parity_status_pkg::ADDR_GEN_ONE_ERR] = addr_gen_one_err; // R12
      // Data-memory read wins over a simultaneous program-memory read
      detect[parity_status_pkg::ADDR_GEN_TWO_ERR] =
         addr_gen_two_err && !addr_gen_one_err; // R5
      detect[parity_status_pkg::DATA_CACHE_ERR] = data_cache_err; // R15
      detect[parity_status_pkg::PROG_CACHE_ERR] = prog_cache_err; // R15
      detect[parity_status_pkg::SLAVE_PORT_ONE_ERR] =
         slave_port_one_err; // R13
      // First slave port wins over a simultaneous second port
      detect[parity_status_pkg::SLAVE_PORT_TWO_ERR] =
         slave_port_two_err && !slave_port_one_err; // R6
      cat_err[parity_status_pkg::EVT_FETCH] =
         progmem_fetch_err || icache_err;
      cat_err[parity_status_pkg::EVT_DATA] = addr_gen_one_err ||
         addr_gen_two_err || data_cache_err || prog_cache_err;
      cat_err[parity_status_pkg::EVT_SYS] =
         slave_port_one_err || slave_port_two_err;
      // Summary bit rides with its detail bit
      detect[parity_status_pkg::CORE_FETCH_ERR] =
         cat_err[parity_status_pkg::EVT_FETCH]; // R7 R16
      detect[parity_status_pkg::CORE_DATA_ERR] =
         cat_err[parity_status_pkg::EVT_DATA]; // R8 R16
      detect[parity_status_pkg::SYS_XFER_ERR] =
         cat_err[parity_status_pkg::EVT_SYS]; // R9 R16
   end

   // Capture only while no error bit is held; a clear in the same cycle
   // still lets a fresh error in, so no event is lost
   assign capture = ((status_q & ~parity_status_pkg::STATUS_IRQ_MASK) ==
      32'h00000000) || clear_zero; // R2

   // ----------------------------------------------------------------
   // Status register
   // ----------------------------------------------------------------
   always_comb begin
      status_d = clear_zero ? parity_status_pkg::STATUS_RESET
         : status_q; // R3
      if (capture) begin
         status_d = status_d | detect; // R1
      end
      // Flags follow the core latch, set wins over a clear
      if (fetch_irq_latched) begin
         status_d[parity_status_pkg::CORE_FETCH_IRQ_FLAG] = 1'b1; // R10 R7
      end
      if (data_irq_latched) begin
         status_d[parity_status_pkg::CORE_DATA_IRQ_FLAG] = 1'b1; // R10 R8
      end
      if (sys_irq_latched) begin
         status_d[parity_status_pkg::SYS_XFER_IRQ_FLAG] = 1'b1; // R10 R9
      end
      status_d = status_d & parity_status_pkg::STATUS_IMPL_MASK; // R16
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         status_q <= parity_status_pkg::STATUS_RESET; // R17
      end else begin
         status_q <= status_d;
      end
   end

   // ----------------------------------------------------------------
   // Event, mask and interrupt output
   // ----------------------------------------------------------------
   always_comb begin
      evt_d = evt_q;
      if (wr_event && byteenable[0]) begin
         evt_d = evt_q & ~writedata[2:0];
      end
      if (capture) begin
         evt_d = evt_d | cat_err;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         evt_q <= parity_status_pkg::EVT_RESET;
      end else begin
         evt_q <= evt_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mask_q <= parity_status_pkg::MASK_RESET;
      end else if (wr_mask && byteenable[0]) begin
         mask_q <= writedata[2:0];
      end
   end

   // Registered level; lags the unmasked events (event and mask) by one cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(evt_q & mask_q);
      end
   end

   // ----------------------------------------------------------------
   // Bus answer
   // ----------------------------------------------------------------
   always_comb begin
      unique case (address)
         parity_status_pkg::STATUS_OFS: rd_mux = status_q;
         parity_status_pkg::EVENT_OFS: rd_mux = {29'h0, evt_q};
         parity_status_pkg::MASK_OFS: rd_mux = {29'h0, mask_q};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // One wait cycle: waitrequest drops for one cycle per request
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= !((read || write) && wait_q);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdata_q <= 32'h00000000;
      end else if (read && wait_q) begin
         rdata_q <= rd_mux;
      end
   end

   assign readdata = rdata_q;
   assign waitrequest = wait_q;
   assign parity_interrupt = irq_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence take_s(logic e);
      capture && e;
   endsequence

   sequence quiet_s;
      !fetch_irq_latched && !data_irq_latched && !sys_irq_latched;
   endsequence

   lock_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // R2
      (status_q & ~parity_status_pkg::STATUS_IRQ_MASK) != 32'h0 &&
      !clear_zero |=> $stable(status_q &
      ~parity_status_pkg::STATUS_IRQ_MASK))
      else $error("locked status changed");

   zero_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // R3
      (clear_zero && detect == 32'h0) and quiet_s |=> status_q == 32'h0)
      else $error("write of zero did not clear");

   dm_priority_a: assert property (@(posedge clk) disable iff (!rst_b) // R5
      take_s(addr_gen_one_err && addr_gen_two_err) |=>
      status_q[parity_status_pkg::ADDR_GEN_ONE_ERR] &&
      !status_q[parity_status_pkg::ADDR_GEN_TWO_ERR])
      else $error("program-memory error kept beside data-memory");

   s1_priority_a: assert property (@(posedge clk) disable iff (!rst_b) // R6
      take_s(slave_port_one_err && slave_port_two_err) |=>
      status_q[parity_status_pkg::SLAVE_PORT_ONE_ERR] &&
      !status_q[parity_status_pkg::SLAVE_PORT_TWO_ERR])
      else $error("second slave port error kept");

   fetch_bits_a: assert property (@(posedge clk) disable iff (!rst_b) // R7
      take_s(progmem_fetch_err) |=>
      status_q[parity_status_pkg::CORE_FETCH_ERR] &&
      status_q[parity_status_pkg::PROGMEM_FETCH_ERR])
      else $error("fetch error bits missing");

   data_bits_a: assert property (@(posedge clk) disable iff (!rst_b) // R8
      take_s(addr_gen_one_err || data_cache_err) |=>
      status_q[parity_status_pkg::CORE_DATA_ERR] &&
      (status_q[parity_status_pkg::ADDR_GEN_ONE_ERR] ||
      status_q[parity_status_pkg::DATA_CACHE_ERR]))
      else $error("data error bits missing");

   sys_bits_a: assert property (@(posedge clk) disable iff (!rst_b) // R9
      take_s(slave_port_two_err && !slave_port_one_err) |=>
      status_q[parity_status_pkg::SYS_XFER_ERR] &&
      status_q[parity_status_pkg::SLAVE_PORT_TWO_ERR])
      else $error("system transfer error bits missing");

   irq_flag_a: assert property (@(posedge clk) disable iff (!rst_b) // R10
      $rose(status_q[parity_status_pkg::CORE_FETCH_IRQ_FLAG]) |->
      $past(fetch_irq_latched))
      else $error("interrupt flag set without latch");

   data_flag_a: assert property (@(posedge clk) disable iff (!rst_b) // R10
      $rose(status_q[parity_status_pkg::CORE_DATA_IRQ_FLAG]) |->
      $past(data_irq_latched))
      else $error("data interrupt flag set without latch");

   sys_flag_a: assert property (@(posedge clk) disable iff (!rst_b) // R10
      $rose(status_q[parity_status_pkg::SYS_XFER_IRQ_FLAG]) |->
      $past(sys_irq_latched))
      else $error("system interrupt flag set without latch");

   cache_bits_a: assert property (@(posedge clk) disable iff (!rst_b) // R14
      take_s(icache_err) ##1 1'b1 |->
      status_q[parity_status_pkg::ICACHE_ERR] &&
      status_q[parity_status_pkg::CORE_FETCH_ERR])
      else $error("instruction cache error bits missing");

   reserved_zero_a: assert property (@(posedge clk) // R16
      disable iff (!rst_b) status_q[25:8] == 18'h0)
      else $error("reserved status bits set");

   reset_clear_a: assert property (@(posedge clk) // R17
      disable iff (!rst_b) $rose(rst_b) |-> status_q == 32'h0)
      else $error("status not cleared by reset");

   irq_out_a: assert property (@(posedge clk) disable iff (!rst_b)
      |(evt_q & mask_q) |=> parity_interrupt)
      else $error("unmasked event without interrupt");

   irq_low_a: assert property (@(posedge clk) disable iff (!rst_b)
      !(|(evt_q & mask_q)) |=> !parity_interrupt)
      else $error("interrupt without unmasked event");

   bus_answer_a: assert property (@(posedge clk) disable iff (!rst_b)
      (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
      else $error("waitrequest not one cycle low");
endmodule : l1_parity_error_status

// file: dv/parity_irq_latch_model.sv
// Core interrupt latch model answering the parity interrupt request.
`timescale 1ns/1ps
module parity_irq_latch_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Request from the block and categories the core will latch
   input wire logic parity_interrupt,
   input wire logic [2:0] pending,
   // Latch strobes back to the block
   output logic fetch_irq_latched,
   output logic data_irq_latched,
   output logic sys_irq_latched
);
   logic irq_q;

   // ----------------------------------------------------------------
   // Latch once per rising request
   // ----------------------------------------------------------------
   // A held level is not relatched, as a real latch only sees the edge
   always_ff @(posedge clk) begin
      irq_q <= rst_b & parity_interrupt;
      {sys_irq_latched, data_irq_latched, fetch_irq_latched} <=
         (rst_b && parity_interrupt && !irq_q) ? pending : 3'h0;
   end
endmodule : parity_irq_latch_model

// file: dv/l1_parity_error_status_tb.sv
// Self-checking testbench for the parity error status collector.
`timescale 1ns/1ps
module l1_parity_error_status_tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] errv = 8'h00;
   logic [2:0] pend = 3'h0;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h00000000;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] readdata;
   logic [31:0] rd;
   logic [31:0] mst = 32'h00000000;
   logic [2:0] mev = 3'h0;
   logic [2:0] mmask = 3'h0;
   logic waitrequest;
   logic parity_interrupt;
   logic f_lat;
   logic d_lat;
   logic s_lat;
   int fails = 0;
   int total_checks = 0;
   int seed = 32'hBA1441AF;
   logic [31:0] m;
   logic [7:0] tbl [11] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04,
                            8'h02, 8'h01, 8'h60, 8'h18, 8'hFF};

   always #5 clk = ~clk;

   l1_parity_error_status i_dut (.clk(clk), .rst_b(rst_b),
      .progmem_fetch_err(errv[7]), .addr_gen_one_err(errv[6]),
      .addr_gen_two_err(errv[5]), .slave_port_two_err(errv[4]),
      .slave_port_one_err(errv[3]), .icache_err(errv[2]),
      .data_cache_err(errv[1]), .prog_cache_err(errv[0]),
      .fetch_irq_latched(f_lat), .data_irq_latched(d_lat),
      .sys_irq_latched(s_lat), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest),
      .parity_interrupt(parity_interrupt));

   parity_irq_latch_model i_core (.clk(clk), .rst_b(rst_b),
      .parity_interrupt(parity_interrupt), .pending(pend),
      .fetch_irq_latched(f_lat), .data_irq_latched(d_lat),
      .sys_irq_latched(s_lat));

   // ----------------------------------------------------------------
   // Comparison and closing
   // ----------------------------------------------------------------
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected read at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_irq(input logic exp);
      total_checks++;
      if (parity_interrupt !== exp) begin
         fails++;
         $display("unexpected irq at %0t: got %h exp %h", $time,
                  parity_interrupt, exp);
      end
   endtask : chk_irq

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results

   // ----------------------------------------------------------------
   // Bus access, model and handler
   // ----------------------------------------------------------------
   // Request is held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] wd);
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= wd;
      // Only the watchdog ends a wait that never sees waitrequest low
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h00000000);
      chk_reg(rd, exp);
   endtask : rdc

   task automatic step(input logic [7:0] e);
      logic [7:0] d;
      logic [2:0] c;
      logic [2:0] pf;
      d = e;
      c = 3'h0;
      pf = 3'h0;
      if ((mst & parity_status_pkg::STATUS_IMPL_MASK &
           ~parity_status_pkg::STATUS_IRQ_MASK) == 32'h00000000) begin
         if (d[6]) d[5] = 1'b0;
         if (d[3]) d[4] = 1'b0;
         c = {|d[4:3], |{d[6:5], d[1:0]}, d[7] | d[2]};
         mst = mst | {c[0], 1'b0, c[1], 1'b0, c[2], 19'h0, d};
      end
      if (!(|(mev & mmask))) pf = (mev | c) & mmask;
      mev = mev | c;
      mst = mst | {1'b0, pf[0], 1'b0, pf[1], 1'b0, pf[2], 26'h0};
      pend <= pf;
      errv <= e;
      @(posedge clk);
      errv <= 8'h00;
      repeat (4) @(posedge clk);
      pend <= 3'h0;
   endtask : step

   // Handler software: clear status by writing zero, then the events
   task automatic handler;
      bus(1'b1, parity_status_pkg::STATUS_OFS, 32'h00000000);
      bus(1'b1, parity_status_pkg::EVENT_OFS, 32'h00000007);
      mst = 32'h00000000;
      mev = 3'h0;
   endtask : handler

   task automatic iter(input logic [7:0] e, input logic [2:0] k,
                       input logic clr);
      mmask = k;
      bus(1'b1, parity_status_pkg::MASK_OFS, {29'h0, k});
      step(e);
      chk_irq(|(mev & mmask));
      rdc(parity_status_pkg::STATUS_OFS, mst);
      rdc(parity_status_pkg::EVENT_OFS, {29'h0, mev});
      rdc(parity_status_pkg::MASK_OFS, {29'h0, mmask});
      if (clr) handler();
      else bus(1'b1, parity_status_pkg::STATUS_OFS, m | 32'h1);
      repeat (2) @(posedge clk);
      chk_irq(|(mev & mmask));
      rdc(parity_status_pkg::STATUS_OFS, mst);
   endtask : iter

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      #200000;
      fails++;
      results();
   end

   initial begin
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rdc(parity_status_pkg::STATUS_OFS, 32'h00000000);
      rdc(4'hC, 32'h00000000);
      bus(1'b1, 4'hC, 32'hFFFFFFFF);
      m = 32'h00000000;
      foreach (tbl[i]) iter(tbl[i], 3'h7, 1'b1);
      iter(8'h14, 3'h0, 1'b1);
      // Clear counts only the enabled lanes of a status write
      iter(8'h40, 3'h0, 1'b0);
      byteenable <= 4'h2;
      bus(1'b1, parity_status_pkg::STATUS_OFS, 32'h0000FF00);
      rdc(parity_status_pkg::STATUS_OFS, mst);
      byteenable <= 4'h1;
      bus(1'b1, parity_status_pkg::STATUS_OFS, 32'hFFFFFF00);
      byteenable <= 4'hF;
      mst = 32'h00000000;
      rdc(parity_status_pkg::STATUS_OFS, mst);
      for (int i = 0; i < 40; i++) begin
         m = $random(seed);
         iter(m[15:8], m[2:0], m[16]);
      end
      iter(8'h20, 3'h7, 1'b0);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rdc(parity_status_pkg::STATUS_OFS, 32'h00000000);
      rdc(parity_status_pkg::EVENT_OFS, 32'h00000000);
      chk_irq(1'b0);
      results();
   end
endmodule : l1_parity_error_status_tb
